// *** src/cswt_consts.svh ***
// Constants for the cyclic sense and wake timers.
`ifndef CSWT_CONSTS_SVH
`define CSWT_CONSTS_SVH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define CSWT_ADDR_WAKE  7'h05
`define CSWT_ADDR_TIMER 7'h06
`define CSWT_RST_WAKE   16'h0020
`define CSWT_RST_TIMER  16'h0000
`define CSWT_MASK_WAKE  16'h3e67
`define CSWT_MASK_TIMER 16'heff7
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSWT_T2_ON   15:13
`define CSWT_T2_PER  11:9
`define CSWT_CYCWAKE 8:7
`define CSWT_T1_ON   6:4
`define CSWT_T1_PER  2:0
`define CSWT_W_FILT  13:11
`define CSWT_W_EN    6:5
`define CSWT_W_BANK  2:0
// ----------------------------------------
// Field codes
// ----------------------------------------
`define CSWT_EN_ON      2'h1
`define CSWT_EN_SYNC    2'h2
`define CSWT_BANK_4     3'h3
`define CSWT_FILT_64    3'h1
`define CSWT_FILT_T1    3'h2
`define CSWT_FILT_T2    3'h3
`define CSWT_ON_LOW     3'h0
`define CSWT_ON_MAXRUN  3'h5
// ----------------------------------------
// Clock rate in MHz; times in microseconds
// ----------------------------------------
`define CSWT_CLK_MHZ 250
`define CSWT_ON1_US  100
`define CSWT_ON2_US  300
`define CSWT_ON3_US  1000
`define CSWT_ON4_US  10000
`define CSWT_ON5_US  20000
`define CSWT_PER0_US 10000
`define CSWT_PER1_US 20000
`define CSWT_PER2_US 50000
`define CSWT_PER3_US 100000
`define CSWT_PER4_US 200000
`define CSWT_PER5_US 500000
`define CSWT_PER6_US 1000000
`define CSWT_PER7_US 2000000
`define CSWT_FILT16_US 16
`define CSWT_FILT64_US 64
`endif

// *** src/cswt_pkg.sv ***
// Types shared by the cyclic sense and wake timers.
package cswt_pkg;
   typedef logic [2:0]  cswt_code_t;
   typedef logic [20:0] cswt_us_t;
   typedef enum logic [1:0] {
      CSWT_WAKE_NONE,
      CSWT_WAKE_T1,
      CSWT_WAKE_T2,
      CSWT_WAKE_RSVD
   } cswt_wake_sel_t;
endpackage : cswt_pkg

// *** src/cswt_top.sv ***
// Two cyclic sense timers, cyclic wake and wake input filtering.
// Functional notes
// - Second timer on/period at 15:13 and 11:9; first at 6:4 and 2:0.
// - On-time codes 1 to 5 give 0.1, 0.3, 1, 10, 20 ms.
// - On-time code 000 stops the timer, output held low.
// - On-time code 110 stops the timer, output held high.
// - On-time code 111 behaves like 110.
// - Period codes give 10,20,50,100,200,500 ms, 1 s, 2 s.
// - First timer period uses the same encoding at bits 2:0.
// - Cyclic wake field 00 blocks wake events from both timers.
// - Wake field 01 picks first timer, 10 second; 11 reserved.
// - Bits 12 and 3 of the timer register read zero.
// - Timer assigned first, then starts once a running on-time is set.
// - Restart clearing an output clears that timer's period and on-time.
// - Other failures leave the timer settings unchanged.
// - Wake source timer keeps sensing and waking together.
// - Wake control register resets to 0x0020.
// - Sync sensing only while wake bank 4 is selected.
// - Fail-Safe entry forces wake enable field to 01.
// - Fail-Safe ignores wake filter, uses static 16 us.
// - Filter codes 010/011 sample wake at on-time end, 16 us.
`include "cswt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cswt_top
   import cswt_pkg::*;
#(
   parameter int unsigned US_CYCLES = `CSWT_CLK_MHZ
) (
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // Register port.
   input  wire logic        reg_wr_en,
   input  wire logic [6:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   output logic      [15:0] reg_rdata,
   // Device status.
   input  wire logic [1:0]  timer_assigned,
   input  wire logic [1:0]  restart_clear,
   input  wire logic        fail_safe_entry,
   input  wire logic        fail_safe_active,
   input  wire logic        wake_pin,
   // Timer and wake outputs.
   output logic      [1:0]  interval_out,
   output logic      [1:0]  on_time_end,
   output logic             periodic_wake,
   output logic             wake_level,
   output logic             wake_event,
   output logic             sync_sense_enable
);
   // ----------------------------------------
   // Registers and microsecond tick
   // ----------------------------------------
   logic [15:0] timer_q;
   logic [15:0] wake_q;
   logic [15:0] rdata_q;
   logic [15:0] pre_q;
   logic        tick;
   cswt_code_t  on_c [2];
   cswt_code_t  per_c [2];
   logic [1:0]  run;
   logic [1:0]  start_p;
   cswt_wake_sel_t wsel;

   assign on_c[0]  = timer_q[`CSWT_T1_ON];
   assign per_c[0] = timer_q[`CSWT_T1_PER];
   assign on_c[1]  = timer_q[`CSWT_T2_ON];
   assign per_c[1] = timer_q[`CSWT_T2_PER];
   assign wsel     = cswt_wake_sel_t'(timer_q[`CSWT_CYCWAKE]);
   assign tick     = (pre_q == 16'(US_CYCLES - 1));
   assign reg_rdata = rdata_q;

   // Prescaler gives one tick per microsecond.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pre_q <= 16'h0000;
      end else if (tick) begin
         pre_q <= 16'h0000;
      end else begin
         pre_q <= pre_q + 16'h0001;
      end
   end

   // Timer control; a restart clear beats a write in the same cycle.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_q <= `CSWT_RST_TIMER;
      end else begin
         logic [15:0] t;
         t = timer_q;
         if (reg_wr_en && reg_addr == `CSWT_ADDR_TIMER) begin
            t = reg_wdata & `CSWT_MASK_TIMER;
         end
         // Of the status inputs, only a restart clear touches the settings.
         if (restart_clear[0]) begin
            t[`CSWT_T1_ON]  = 3'h0;
            t[`CSWT_T1_PER] = 3'h0;
         end
         if (restart_clear[1]) begin
            t[`CSWT_T2_ON]  = 3'h0;
            t[`CSWT_T2_PER] = 3'h0;
         end
         timer_q <= t;
      end
   end

   // Wake control; Fail-Safe entry overrides the enable field.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_q <= `CSWT_RST_WAKE;
      end else begin
         logic [15:0] w;
         w = wake_q;
         if (reg_wr_en && reg_addr == `CSWT_ADDR_WAKE) begin
            w = reg_wdata & `CSWT_MASK_WAKE;
         end
         if (fail_safe_entry) begin
            w[`CSWT_W_EN] = `CSWT_EN_ON;
         end
         wake_q <= w;
      end
   end

   // Read data is registered; unmapped offsets read zero.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 16'h0000;
      end else if (reg_addr == `CSWT_ADDR_TIMER) begin
         rdata_q <= timer_q;
      end else if (reg_addr == `CSWT_ADDR_WAKE) begin
         rdata_q <= wake_q;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   a_reserved_zero : assert property (@(posedge sys_clk) disable iff (!arst_n)
      $past(reg_addr) == `CSWT_ADDR_TIMER |-> !reg_rdata[12] && !reg_rdata[3])
      else $error("Reserved timer bits read nonzero.");
   a_failsafe_enable : assert property (@(posedge sys_clk) disable iff (!arst_n)
      fail_safe_entry |=> wake_q[`CSWT_W_EN] == `CSWT_EN_ON)
      else $error("Fail-Safe entry did not force wake enable.");

   // ----------------------------------------
   // Interval timers
   // ----------------------------------------
   function automatic cswt_us_t on_us(input cswt_code_t c);
      unique case (c)
         3'h1:    on_us = 21'(`CSWT_ON1_US);
         3'h2:    on_us = 21'(`CSWT_ON2_US);
         3'h3:    on_us = 21'(`CSWT_ON3_US);
         3'h4:    on_us = 21'(`CSWT_ON4_US);
         3'h5:    on_us = 21'(`CSWT_ON5_US);
         default: on_us = 21'h000000;
      endcase
   endfunction : on_us

   function automatic cswt_us_t per_us(input cswt_code_t c);
      unique case (c)
         3'h0: per_us = 21'(`CSWT_PER0_US);
         3'h1: per_us = 21'(`CSWT_PER1_US);
         3'h2: per_us = 21'(`CSWT_PER2_US);
         3'h3: per_us = 21'(`CSWT_PER3_US);
         3'h4: per_us = 21'(`CSWT_PER4_US);
         3'h5: per_us = 21'(`CSWT_PER5_US);
         3'h6: per_us = 21'(`CSWT_PER6_US);
         3'h7: per_us = 21'(`CSWT_PER7_US);
      endcase
   endfunction : per_us

   for (genvar gi = 0; gi < 2; gi++) begin : g_tmr
      cswt_us_t cnt_q;
      logic     out_q;
      logic     end_q;
      logic     wrap;

      // Starts only once assigned and given a running on-time.
      assign run[gi] = timer_assigned[gi] && on_c[gi] != `CSWT_ON_LOW
                       && on_c[gi] <= `CSWT_ON_MAXRUN;
      assign wrap = tick && cnt_q >= per_us(per_c[gi]) - 21'h000001;
      assign start_p[gi] = run[gi] && wrap;

      // Period counter; held at zero while stopped so a start is clean.
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            cnt_q <= 21'h000000;
         end else if (!run[gi] || wrap) begin
            cnt_q <= 21'h000000;
         end else if (tick) begin
            cnt_q <= cnt_q + 21'h000001;
         end
      end

      // Output level; stopped codes give static low or high.
      always_ff @(posedge sys_clk or negedge arst_n) begin
         if (!arst_n) begin
            out_q <= 1'b0;
            end_q <= 1'b0;
         end else if (run[gi]) begin
            out_q <= cnt_q < on_us(on_c[gi]);
            end_q <= tick && cnt_q == on_us(on_c[gi]) - 21'h000001;
         end else begin
            out_q <= on_c[gi] > `CSWT_ON_MAXRUN;
            end_q <= 1'b0;
         end
      end
      assign interval_out[gi] = out_q;
      assign on_time_end[gi]  = end_q;

      a_off_low : assert property (@(posedge sys_clk) disable iff (!arst_n)
         on_c[gi] == `CSWT_ON_LOW |=> !out_q)
         else $error("Stopped-low timer output is high.");
      a_off_high : assert property (@(posedge sys_clk) disable iff (!arst_n)
         on_c[gi] > `CSWT_ON_MAXRUN |=> out_q && !end_q)
         else $error("Stopped-high timer output is low.");
      a_restart_clears : assert property (@(posedge sys_clk) disable iff (!arst_n)
         restart_clear[gi] |=> on_c[gi] == 3'h0 && per_c[gi] == 3'h0 && !run[gi])
         else $error("Restart clear left timer settings.");
      a_period_wrap : assert property (@(posedge sys_clk) disable iff (!arst_n)
         start_p[gi] |=> cnt_q == 21'h000000 ##1 out_q)
         else $error("Period restart did not raise output.");
   end

   // ----------------------------------------
   // Cyclic wake
   // ----------------------------------------
   logic wake_p_q;

   // Wake pulses ride on the period start; sensing keeps running.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_p_q <= 1'b0;
      end else begin
         unique case (wsel)
            CSWT_WAKE_T1: wake_p_q <= start_p[0];
            CSWT_WAKE_T2: wake_p_q <= start_p[1];
            CSWT_WAKE_NONE,
            CSWT_WAKE_RSVD: wake_p_q <= 1'b0;
         endcase
      end
   end
   assign periodic_wake = wake_p_q;

   a_wake_disabled : assert property (@(posedge sys_clk) disable iff (!arst_n)
      wsel == CSWT_WAKE_NONE || wsel == CSWT_WAKE_RSVD |=> !periodic_wake)
      else $error("Cyclic wake fired while disabled.");

   // ----------------------------------------
   // Wake input filter
   // ----------------------------------------
   logic [2:0] sync_q;
   logic       last_q;
   logic [6:0] flt_q;
   logic       lvl_q;
   logic       evt_q;
   logic [2:0] fcode;
   logic       cyc_mode;
   logic       sample;
   logic [6:0] need;
   logic       wk_on;

   assign fcode    = wake_q[`CSWT_W_FILT];
   assign wk_on    = wake_q[`CSWT_W_EN] == `CSWT_EN_ON;
   // Fail-Safe falls back to static 16 us whatever is set.
   assign cyc_mode = !fail_safe_active && (fcode == `CSWT_FILT_T1 || fcode == `CSWT_FILT_T2);
   assign need     = (!fail_safe_active && fcode == `CSWT_FILT_64) ?
                     7'(`CSWT_FILT64_US) : 7'(`CSWT_FILT16_US);
   // Cyclic modes look only at the end of the chosen on-time.
   assign sample   = cyc_mode ? on_time_end[fcode == `CSWT_FILT_T2] : 1'b1;
   assign sync_sense_enable = wake_q[`CSWT_W_EN] == `CSWT_EN_SYNC
                              && wake_q[`CSWT_W_BANK] == `CSWT_BANK_4;

   // Pin synchroniser; a change counts once stages two and three agree.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync_q <= 3'h0;
      end else begin
         sync_q <= {sync_q[1:0], wake_pin};
      end
   end

   // Stability counter in microseconds, saturating.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         last_q <= 1'b0;
         flt_q  <= 7'h00;
      end else if (sync_q[1] == sync_q[2]) begin
         last_q <= sync_q[2];
         if (sync_q[2] != last_q) begin
            flt_q <= 7'h00;
         end else if (tick && flt_q != 7'h7f) begin
            flt_q <= flt_q + 7'h01;
         end
      end
   end

   // Filtered level; events only while the wake module is on or Fail-Safe is active.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lvl_q <= 1'b0;
         evt_q <= 1'b0;
      end else begin
         evt_q <= 1'b0;
         if ((wk_on || fail_safe_active) && sample && flt_q >= need && last_q != lvl_q) begin
            lvl_q <= last_q;
            evt_q <= 1'b1;
         end
      end
   end
   assign wake_level = lvl_q;
   assign wake_event = evt_q;

   a_sync_bank : assert property (@(posedge sys_clk) disable iff (!arst_n)
      sync_sense_enable |-> wake_q[`CSWT_W_BANK] == `CSWT_BANK_4)
      else $error("Sync sensing outside bank 4.");
   a_cyclic_sample : assert property (@(posedge sys_clk) disable iff (!arst_n)
      cyc_mode && !sample |=> !wake_event)
      else $error("Cyclic wake sampled outside on-time end.");
endmodule : cswt_top
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking testbench for the cyclic sense and wake timers.
`include "cswt_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ---------------------------------------------
   // Stimulus signals and the block under test
   // ---------------------------------------------
   localparam int unsigned US = 2;  // A short tick keeps whole periods affordable.
   logic        sys_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        reg_wr_en = 1'b0;
   logic [6:0]  reg_addr = 7'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [15:0] reg_rdata;
   logic [1:0]  timer_assigned = 2'h0;
   logic [1:0]  restart_clear = 2'h0;
   logic        fail_safe_entry = 1'b0;
   logic        fail_safe_active = 1'b0;
   logic        wake_pin = 1'b0;
   logic [1:0]  interval_out;
   logic [1:0]  on_time_end;
   logic        periodic_wake;
   logic        wake_level;
   logic        wake_event;
   logic        sync_sense_enable;
   int          num_errors = 0;
   int          n_compared = 0;
   int          wake_cnt = 0;
   int          ote_cnt = 0;
   int          evt_cnt = 0;
   int          hi;
   int          lo;
   logic [31:0] rnd = 32'h2d18;
   logic [15:0] v;
   logic [15:0] run_img [3] = '{16'h2010, 16'h2090, 16'h2100};

   cswt_top #(.US_CYCLES(US)) u_cswt_top (
      .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .timer_assigned(timer_assigned),
      .restart_clear(restart_clear), .fail_safe_entry(fail_safe_entry),
      .fail_safe_active(fail_safe_active), .wake_pin(wake_pin), .interval_out(interval_out),
      .on_time_end(on_time_end), .periodic_wake(periodic_wake), .wake_level(wake_level),
      .wake_event(wake_event), .sync_sense_enable(sync_sense_enable)
   );

   // Free-running clock, 4 ns period.
   always #2 sys_clk = ~sys_clk;

   // Pulse counters, so a scenario can ask how many events a window held.
   always @(posedge sys_clk) begin
      if (periodic_wake === 1'b1) begin
         wake_cnt++;
      end
      if (on_time_end[0] === 1'b1) begin
         ote_cnt++;
      end
      if (wake_event === 1'b1) begin
         evt_cnt++;
      end
   end

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [15:0] xorshift();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd[15:0];
   endfunction : xorshift

   function automatic int on_us(input int c);
      case (c)
         1: return 100;
         2: return 300;
         3: return 1000;
         default: return 0;
      endcase
   endfunction : on_us

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   // Writes hold their strobe for exactly one taking edge.
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      cyc(1);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr_en = 1'b0;
   endtask : wr

   // Read data is registered, so it settles one edge after the address; the check waits two.
   task automatic rdc(input string name, input logic [6:0] a, input logic [15:0] exp);
      cyc(1);
      reg_addr = a;
      cyc(2);
      chk(name, exp, reg_rdata);
   endtask : rdc

   // Waits for a rise, then times the high phase and optionally the low phase.
   task automatic meas(input int i, input int lim, input int lim_lo);
      int n;
      n = 0;
      hi = 0;
      lo = 0;
      while (interval_out[i] !== 1'b1 && n < lim) begin
         cyc(1);
         n++;
      end
      while (interval_out[i] === 1'b1 && hi < lim) begin
         cyc(1);
         hi++;
      end
      while (interval_out[i] !== 1'b1 && lo < lim_lo) begin
         cyc(1);
         lo++;
      end
   endtask : meas

   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   // Main sequence.
   initial begin
      cyc(3);
      arst_n = 1'b1;
      rdc("wake reset", `CSWT_ADDR_WAKE, 16'h0020);
      rdc("timer reset", `CSWT_ADDR_TIMER, 16'h0000);
      rdc("unmapped", 7'h07, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         v = xorshift();
         wr(`CSWT_ADDR_TIMER, v);
         rdc("timer image", `CSWT_ADDR_TIMER, v & 16'heff7);
         v = xorshift();
         wr(`CSWT_ADDR_WAKE, v);
         rdc("wake image", `CSWT_ADDR_WAKE, v & 16'h3e67);
      end
      $display("test register map done");
      wr(`CSWT_ADDR_TIMER, 16'h0010);
      cyc(300);
      chk("unassigned out", 2'b00, interval_out);
      timer_assigned = 2'b11;
      wr(`CSWT_ADDR_TIMER, 16'hc000);
      cyc(3);
      chk("codes 0 and 6", 2'b10, interval_out);
      wr(`CSWT_ADDR_TIMER, 16'h0070);
      cyc(3);
      chk("codes 7 and 0", 2'b01, interval_out);
      $display("test static levels done");
      for (int c = 1; c <= 5; c++) begin
         wr(`CSWT_ADDR_TIMER, 16'h0080);
         ote_cnt = 0;
         wr(`CSWT_ADDR_TIMER, {9'h001, c[2:0], 4'h0});
         meas(0, 3000, 0);
         if (c < 4) begin
            chk("on width", 1'b1, hi > (on_us(c) - 1) * US && hi <= on_us(c) * US);
            chk("on end pulses", 1, ote_cnt);
         end else begin
            chk("held on", 3000, hi);
         end
      end
      $display("test on times done");
      // Runs with wake select 00, 01 and 10; the last leaves the first timer stopped.
      for (int s = 0; s < 3; s++) begin
         wr(`CSWT_ADDR_TIMER, 16'h0000);
         wr(`CSWT_ADDR_TIMER, run_img[s]);
         wake_cnt = 0;
         meas(s / 2, 3000, 25000);
         cyc(4);
         chk("low time", (10000 - 100) * US, lo);
         chk("wake seen", s != 0, wake_cnt != 0);
      end
      $display("test periods done");
      for (int i = 0; i < 2; i++) begin
         v = xorshift() & 16'heff7;
         wr(`CSWT_ADDR_TIMER, v);
         restart_clear[i] = 1'b1;
         cyc(1);
         restart_clear[i] = 1'b0;
         rdc("restart clear", `CSWT_ADDR_TIMER, i ? v & 16'h11ff : v & 16'hff88);
      end
      wr(`CSWT_ADDR_WAKE, 16'h0040);
      cyc(2);
      chk("sync other bank", 1'b0, sync_sense_enable);
      wr(`CSWT_ADDR_WAKE, 16'h0043);
      cyc(2);
      chk("sync bank 4", 1'b1, sync_sense_enable);
      fail_safe_entry = 1'b1;
      cyc(1);
      fail_safe_entry = 1'b0;
      rdc("fail safe enable", `CSWT_ADDR_WAKE, 16'h0023);
      rdc("timer kept", `CSWT_ADDR_TIMER, v & 16'h11ff);
      // Sampling at the first timer's on-time end; a static filter would settle far sooner.
      wr(`CSWT_ADDR_TIMER, 16'h0000);
      wr(`CSWT_ADDR_TIMER, 16'h0010);
      wr(`CSWT_ADDR_WAKE, 16'h1020);
      wake_pin = 1'b1;
      ote_cnt = 0;
      evt_cnt = 0;
      cyc(30 * US);
      chk("cyclic hold", 1'b0, wake_level);
      hi = 0;
      while (wake_level !== 1'b1 && hi < 200 * US) begin
         cyc(1);
         hi++;
      end
      chk("cyclic on end", 1, ote_cnt);
      cyc(2);
      chk("cyclic event", 1, evt_cnt);
      // The long filter is selected, yet fail-safe must use the short one.
      fail_safe_active = 1'b1;
      wr(`CSWT_ADDR_WAKE, 16'h0800);
      wake_pin = 1'b0;
      hi = 0;
      while (wake_level !== 1'b0 && hi < 200) begin
         cyc(1);
         hi++;
      end
      chk("fail safe filter", 1'b1, hi > 14 * US && hi <= 20 * US + 6);
      cyc(2);
      chk("fail safe event", 2, evt_cnt);
      $display("test restart and fail safe done");
      print_verdict();
   end

   // Watchdog sized above the longest expected run.
   initial begin
      #(4 * 90000);
      num_errors++;
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
